/* verilog/vcs_pkg.sv */
// package: register map, field positions, timing constants for video ctrl regs
package vcs_pkg;
  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OVERLAP = 8'h08;
  localparam logic [7:0] ADDR_COLOUR = 8'h0C;
  localparam logic [7:0] ADDR_YPOS = 8'h10;
  localparam logic [7:0] ADDR_XPOS = 8'h14;
  // ----------------------------------------------------------------
  // control bit positions
  // ----------------------------------------------------------------
  localparam int CTL_HINT = 0;
  localparam int CTL_FSTB = 1;
  localparam int CTL_SINT = 2;
  localparam int CTL_GRID = 3;
  localparam int CTL_XINT = 4;
  localparam int CTL_DISP = 5;
  localparam int CTL_DOT = 6;
  localparam int CTL_WIDE = 7;
  // ----------------------------------------------------------------
  // status bit positions
  // ----------------------------------------------------------------
  localparam int ST_HORIZ = 0;
  localparam int ST_STROBE = 1;
  localparam int ST_SOUND = 2;
  localparam int ST_VERT = 3;
  localparam int ST_EXTOV = 6;
  localparam int ST_MAJOV = 7;
  // overlap bit positions
  localparam int OV_EXT = 6;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] COLOUR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 25000;
  localparam int LINE_DIV = 227;
  localparam int HSTAT_LEAD_US = 20;
  localparam int HSTAT_TRAIL_US = 5;
  localparam int HBL_CYCLES = 40;
  // line counter counts video ticks stepped from the 25 MHz clock, 227 ticks per line
  localparam int VID_TICK_NUM = 354;
  localparam int VID_TICK_DEN = 2500;
  localparam int LEAD_CYC = (HSTAT_LEAD_US * 354 + 99) / 100;
  localparam int TRAIL_CYC = (HSTAT_TRAIL_US * 354) / 100;
  localparam logic [7:0] HBL_START = 8'(LINE_DIV - HBL_CYCLES);
  localparam logic [7:0] HSTAT_ON = 8'(LINE_DIV - HBL_CYCLES - LEAD_CYC);
  localparam logic [7:0] HSTAT_OFF = 8'(LINE_DIV - TRAIL_CYC);
  localparam logic [7:0] HSYNC_ON = 8'(LINE_DIV - HBL_CYCLES + 4);
  localparam logic [7:0] HSYNC_OFF = 8'(LINE_DIV - HBL_CYCLES + 21);
  localparam logic [7:0] BURST_ON = 8'(LINE_DIV - HBL_CYCLES + 24);
  localparam logic [7:0] BURST_OFF = 8'(LINE_DIV - HBL_CYCLES + 33);
  localparam logic [11:0] FRAC_STEP = 12'd354;
  localparam logic [11:0] FRAC_WRAP = 12'd2500;

  typedef struct packed {
    logic horizBlanking;
    logic vertBlanking;
    logic horizSync;
    logic burstGate;
  } vcs_sync_s;

  typedef struct packed {
    logic gridEnable;
    logic dotEnable;
    logic wideGrid;
    logic displayEnable;
    logic [2:0] gridRgb;
    logic [2:0] backRgb;
    logic gridBright;
  } vcs_video_s;
endpackage

/* verilog/vcs_regs.sv */
// video control and status register bank with sync generator
//
// Overview of operation
// [R1] control bit 0 enables early horizontal interrupt; slave mode raises it at incoming blanking
// [R2] control bit 1 forces position strobe internally
// [R3] strobe high tracks, falling edge freezes, x read
// [R4] control bit 2 gates sound interrupt
// [R5] control bit 3 keeps luminance during grid
// [R6] control bit 4 enables external overlap interrupt
// [R7] control bit 5 enables object display
// [R8] host disables display only when idle
// [R9] control bit 6 adds dot array
// [R10] control bit 7 selects wide vertical segments
// [R11] colour latch grid, background, bright bits
// [R12] grid disabled frees grid memory
// [R13] zero mask bit blocks setting others
// [R14] overlap bit order minors, grids, ext, major
// [R15] coincident objects set unmasked overlap bits
// [R16] overlap status cleared by read
// [R17] status bit 0 horizontal window timing
// [R18] status bit 1 tracking versus latched
// [R19] status bits 2, 3 sound, vertical
// [R20] status bits 6, 7 ext, major overlap
// [R21] status read clears bits 2, 6, irq
// [R22] sync generator free runs always
// [R23] master drives four sync, slave takes blanking
// [R24] line rate is video clock over 227
// [R25] interrupt flip-flop held until status read
`timescale 1ns/1ps
module vcs_regs (
  input wire logic clock,
  input wire logic srst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic masterMode,
  input wire logic positionStrobePin,
  input wire logic overlapInputPin,
  input wire logic horizBlankingIn,
  input wire logic vertBlankingIn,
  input wire logic vertBlankingGen,
  input wire logic [7:0] objectActive,
  input wire logic soundEmpty,
  input wire logic majorLoadBusy,
  input wire logic [7:0] beamLocationX,
  input wire logic [7:0] beamLocationY,
  input wire logic gridInterval,
  output vcs_pkg::vcs_sync_s syncOut,
  output vcs_pkg::vcs_video_s videoCtl,
  output logic overlapOutPin,
  output logic lumaGate,
  output logic interruptReq
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q, sync2_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {positionStrobePin, overlapInputPin, horizBlankingIn,
                  vertBlankingIn};
      sync2_q <= sync1_q;
    end
  end
  wire stbPinS = sync2_q[3];
  wire cxPinS = sync2_q[2];
  wire hblInS = sync2_q[1];
  wire vblInS = sync2_q[0];

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic wrPend_q, rdPend_q;
  logic [7:0] addr_q;
  wire accept = hsel & hready & htrans[1];
  always_ff @(posedge clock) begin
    if (srst) begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wrPend_q <= accept & hwrite;
      rdPend_q <= accept & ~hwrite;
      addr_q <= accept ? haddr[7:0] : addr_q;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // reads decode in the address phase so clear-on-read acts once
  wire rdNow = accept & ~hwrite;
  wire rdStatus = rdNow & (haddr[7:0] == vcs_pkg::ADDR_STATUS);
  wire rdOverlap = rdNow & (haddr[7:0] == vcs_pkg::ADDR_OVERLAP);
  wire rdX = rdNow & (haddr[7:0] == vcs_pkg::ADDR_XPOS);
  wire wrCtl = wrPend_q & (addr_q == vcs_pkg::ADDR_CONTROL);
  wire wrColour = wrPend_q & (addr_q == vcs_pkg::ADDR_COLOUR);
  wire wrMask = wrPend_q & (addr_q == vcs_pkg::ADDR_OVERLAP);

  logic [7:0] control_q, colour_q, mask_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      control_q <= vcs_pkg::CONTROL_RST;
      colour_q <= vcs_pkg::COLOUR_RST;
      mask_q <= vcs_pkg::MASK_RST;
    end else begin
      if (wrCtl) control_q <= hwdata[7:0];
      if (wrColour) colour_q <= hwdata[7:0]; // see [R11]
      if (wrMask) mask_q <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // sync generator: 227 video ticks per line from fractional step
  // ----------------------------------------------------------------
  logic [11:0] frac_q;
  logic [7:0] hcount_q;
  wire [12:0] fracSum = {1'b0, frac_q} + {1'b0, vcs_pkg::FRAC_STEP};
  wire vidTick = fracSum >= {1'b0, vcs_pkg::FRAC_WRAP};
  wire lineEnd = vidTick & (hcount_q == 8'(vcs_pkg::LINE_DIV - 1));
  always_ff @(posedge clock) begin
    if (srst) begin
      frac_q <= 12'h000;
      hcount_q <= 8'h00;
    end else begin
      // runs in both modes, only its use differs; see [R22]
      frac_q <= vidTick ? 12'(fracSum - {1'b0, vcs_pkg::FRAC_WRAP})
                        : fracSum[11:0];
      if (vidTick) hcount_q <= lineEnd ? 8'h00 : 8'(hcount_q + 8'h01); // see [R24]
    end
  end
  wire genHbl = hcount_q >= vcs_pkg::HBL_START;
  wire genHsync = (hcount_q >= vcs_pkg::HSYNC_ON) &
                  (hcount_q < vcs_pkg::HSYNC_OFF);
  wire genBurst = (hcount_q >= vcs_pkg::BURST_ON) &
                  (hcount_q < vcs_pkg::BURST_OFF);
  // slave takes only the two blanking signals; see [R23]
  wire hblUsed = masterMode ? genHbl : hblInS;
  wire vblUsed = masterMode ? vertBlankingGen : vblInS;
  // in master mode the status window leads blanking by 20 us, drops 5 us before its end
  wire horizStatus = masterMode ?
    ((hcount_q >= vcs_pkg::HSTAT_ON) & (hcount_q < vcs_pkg::HSTAT_OFF)) :
    hblUsed; // see [R17]
  logic [3:0] syncOut_q;
  always_ff @(posedge clock) begin
    if (srst) syncOut_q <= 4'h0;
    else syncOut_q <= masterMode ?
      {genHbl, vertBlankingGen, genHsync, genBurst} : 4'h0; // see [R23]
  end
  assign syncOut = syncOut_q;

  // ----------------------------------------------------------------
  // position strobe and x-y capture
  // ----------------------------------------------------------------
  wire strobeOr = stbPinS | control_q[vcs_pkg::CTL_FSTB]; // see [R2]
  logic strobeOr_q, frozen_q;
  logic [7:0] xPos_q, yPos_q;
  wire strobeFall = strobeOr_q & ~strobeOr;
  always_ff @(posedge clock) begin
    if (srst) begin
      strobeOr_q <= 1'b0;
      frozen_q <= 1'b0;
      xPos_q <= 8'h00;
      yPos_q <= 8'h00;
    end else begin
      strobeOr_q <= strobeOr;
      // sampled away from video ticks so beam counter is stable; see [R3]
      if (strobeOr & ~vidTick) begin
        xPos_q <= beamLocationX;
        yPos_q <= beamLocationY;
      end
      if (strobeFall) frozen_q <= 1'b1; // see [R3]
      else if (rdX) frozen_q <= 1'b0;
    end
  end
  wire tracking = strobeOr & ~frozen_q; // see [R18]

  // ----------------------------------------------------------------
  // overlap status and chip status
  // ----------------------------------------------------------------
  wire [7:0] objs = {objectActive[7], cxPinS, objectActive[5:0]}; // see [R15]
  wire [7:0] masked = objs & mask_q;
  wire [3:0] maskedCnt = 4'(masked[0]) + 4'(masked[1]) + 4'(masked[2]) +
    4'(masked[3]) + 4'(masked[4]) + 4'(masked[5]) + 4'(masked[6]) +
    4'(masked[7]);
  // an object hidden by its mask bit sets no one else's bit; see [R13]
  wire coincide = (maskedCnt >= 4'h2);
  wire [7:0] ovSet = coincide ? masked : 8'h00; // see [R14]
  logic [7:0] overlap_q;
  logic sndSvc_q, extOv_q, majOv_q, irq_q;
  wire extEvent = cxPinS & (objs[5:0] != 6'h00);
  wire irqSet = (control_q[vcs_pkg::CTL_HINT] & horizStatus) | // see [R1]
    (control_q[vcs_pkg::CTL_SINT] & soundEmpty) | // see [R4]
    (control_q[vcs_pkg::CTL_XINT] & extEvent); // see [R6]
  always_ff @(posedge clock) begin
    if (srst) begin
      overlap_q <= 8'h00;
      sndSvc_q <= 1'b0;
      extOv_q <= 1'b0;
      majOv_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      // set wins over clear-on-read
      overlap_q <= (rdOverlap ? 8'h00 : overlap_q) | ovSet; // see [R16]
      sndSvc_q <= (sndSvc_q & ~rdStatus) | soundEmpty; // see [R19]
      extOv_q <= (extOv_q & ~rdStatus) | extEvent; // see [R20]
      majOv_q <= majOv_q | majorLoadBusy; // see [R20]
      irq_q <= (irq_q & ~rdStatus) | irqSet; // see [R21] [R25]
    end
  end
  assign interruptReq = irq_q;
  assign overlapOutPin = objectActive[7] | (objectActive[5:0] != 6'h00);

  wire [7:0] statusWord = {majOv_q, extOv_q, 2'b00, vblUsed, sndSvc_q,
                           tracking, horizStatus};
  logic [7:0] rdData_q;
  wire [7:0] rdMux =
    (haddr[7:0] == vcs_pkg::ADDR_CONTROL) ? control_q :
    (haddr[7:0] == vcs_pkg::ADDR_STATUS) ? statusWord :
    (haddr[7:0] == vcs_pkg::ADDR_OVERLAP) ? overlap_q :
    (haddr[7:0] == vcs_pkg::ADDR_YPOS) ? yPos_q :
    (haddr[7:0] == vcs_pkg::ADDR_XPOS) ? xPos_q : 8'h00;
  always_ff @(posedge clock) begin
    if (srst) rdData_q <= 8'h00;
    else if (rdNow) rdData_q <= rdMux;
  end
  assign hrdata = {24'h000000, rdData_q};

  // ----------------------------------------------------------------
  // video control outputs
  // ----------------------------------------------------------------
  // grid off leaves grid memory to the host, no rendering reads it
  assign videoCtl.gridEnable = control_q[vcs_pkg::CTL_GRID]; // see [R12]
  assign videoCtl.dotEnable = control_q[vcs_pkg::CTL_DOT]; // see [R9]
  assign videoCtl.wideGrid = control_q[vcs_pkg::CTL_WIDE]; // see [R10]
  assign videoCtl.displayEnable = control_q[vcs_pkg::CTL_DISP]; // see [R7]
  assign videoCtl.gridRgb = colour_q[2:0]; // see [R11]
  assign videoCtl.backRgb = colour_q[5:3];
  assign videoCtl.gridBright = colour_q[6];
  assign lumaGate = ~gridInterval | control_q[vcs_pkg::CTL_GRID]; // see [R5]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  irq_hold_a: assert property (@(posedge clock) disable iff (srst)
    irq_q & ~rdStatus |=> irq_q) // see [R25]
    else $error("interrupt dropped without status read");
  irq_clear_a: assert property (@(posedge clock) disable iff (srst)
    rdStatus & ~irqSet |=> ~irq_q) // see [R21]
    else $error("interrupt not cleared by status read");
  snd_gate_a: assert property (@(posedge clock) disable iff (srst)
    ~irq_q & ~control_q[0] & ~control_q[2] & ~control_q[4] |=> ~irq_q)
    // see [R4]
    else $error("interrupt raised with sources disabled");
  ovl_clear_a: assert property (@(posedge clock) disable iff (srst)
    rdOverlap & ~coincide |=> overlap_q == 8'h00) // see [R16]
    else $error("overlap status not cleared on read");
  ovl_mask_a: assert property (@(posedge clock) disable iff (srst)
    ~overlap_q[0] & ~mask_q[0] & ~wrMask |=> ~overlap_q[0]) // see [R13]
    else $error("masked overlap bit set");
  freeze_a: assert property (@(posedge clock) disable iff (srst)
    strobeFall |=> frozen_q) // see [R3]
    else $error("strobe fall did not freeze");
  hold_x_a: assert property (@(posedge clock) disable iff (srst)
    ~strobeOr & ~$past(strobeOr) |=> $stable(xPos_q)) // see [R3]
    else $error("x position changed while frozen");
  line_len_a: assert property (@(posedge clock) disable iff (srst)
    lineEnd |=> hcount_q == 8'h00) // see [R24]
    else $error("line counter did not wrap");
  slave_sync_a: assert property (@(posedge clock) disable iff (srst)
    ~masterMode ##1 ~masterMode |-> syncOut_q == 4'h0) // see [R23]
    else $error("slave drove sync outputs");

  // ----------------------------------------------------------------
  // rule checks on sources, capture and sync outputs
  // ----------------------------------------------------------------
  // each enabled source must reach the flip-flop on the very next edge
  hint_set_a: assert property (@(posedge clock) disable iff (srst) // see [R1]
    control_q[vcs_pkg::CTL_HINT] & horizStatus |=> irq_q)
    else $error("horizontal interrupt not raised");
  sint_set_a: assert property (@(posedge clock) disable iff (srst) // see [R4]
    control_q[vcs_pkg::CTL_SINT] & soundEmpty |=> irq_q)
    else $error("sound interrupt not raised");
  xint_set_a: assert property (@(posedge clock) disable iff (srst) // see [R6]
    control_q[vcs_pkg::CTL_XINT] & extEvent |=> irq_q)
    else $error("external overlap interrupt not raised");
  snd_flag_a: assert property (@(posedge clock) disable iff (srst) // see [R19]
    soundEmpty |=> sndSvc_q)
    else $error("sound service flag not set");
  ext_flag_a: assert property (@(posedge clock) disable iff (srst) // see [R20]
    extEvent |=> extOv_q)
    else $error("external overlap flag not set");
  maj_flag_a: assert property (@(posedge clock) disable iff (srst) // see [R20]
    majorLoadBusy |=> majOv_q)
    else $error("major overlap flag not set");
  ovl_set_a: assert property (@(posedge clock) disable iff (srst) // see [R15]
    coincide |=> (overlap_q & $past(masked)) == $past(masked))
    else $error("coincident objects not recorded");
  luma_off_a: assert property (@(posedge clock) disable iff (srst) // see [R5]
    gridInterval & ~control_q[vcs_pkg::CTL_GRID] |-> ~lumaGate)
    else $error("luminance active in grid interval");
  xy_track_a: assert property (@(posedge clock) disable iff (srst) // see [R3]
    strobeOr & ~vidTick |=> xPos_q == $past(beamLocationX))
    else $error("x position did not follow beam");
  unfreeze_a: assert property (@(posedge clock) disable iff (srst) // see [R3]
    rdX & ~strobeFall |=> ~frozen_q)
    else $error("x read did not release freeze");
  hstat_on_a: assert property (@(posedge clock) disable iff (srst) // see [R17]
    masterMode & (hcount_q == vcs_pkg::HSTAT_ON) |-> horizStatus)
    else $error("horizontal status not raised in time");
  count_step_a: assert property (@(posedge clock) disable iff (srst) // see [R24]
    vidTick & ~lineEnd |=> hcount_q == 8'($past(hcount_q) + 8'h01))
    else $error("line counter skipped a tick");
  master_hbl_a: assert property (@(posedge clock) disable iff (srst) // see [R23]
    masterMode |=> syncOut_q[3] == $past(genHbl))
    else $error("master blanking output wrong");
  ctl_write_a: assert property (@(posedge clock) disable iff (srst) // see [R7]
    wrCtl |=> control_q == $past(hwdata[7:0]))
    else $error("control write lost");
  colour_wr_a: assert property (@(posedge clock) disable iff (srst) // see [R11]
    wrColour |=> colour_q == $past(hwdata[7:0]))
    else $error("colour latch write lost");
  cov_master_c: cover property (@(posedge clock) masterMode & lineEnd);
  cov_snd_c: cover property (@(posedge clock) soundEmpty ##1 rdStatus);
  cov_irq_c: cover property (@(posedge clock) irqSet ##1 rdStatus);
  cov_ovl_c: cover property (@(posedge clock) coincide ##1 rdOverlap);
  cov_frz_c: cover property (@(posedge clock) strobeFall ##[1:20] rdX);
endmodule

/* dv/vcs_host_model.sv */
// host processor model: single-word bus master for the register bank
`timescale 1ns/1ps
module vcs_host_model (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hsel
);
  initial begin
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    hsel = 1'b0;
  end

  // called just after a rising edge; the caller never assumes a latency
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] wd, output logic [7:0] rdv);
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    hsel <= 1'b1;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rdv = hrdata[7:0];
  endtask
endmodule

/* dv/vcs_regs_tb_top.sv */
// top testbench: host bus tests of the video control and status registers
`timescale 1ns/1ps
module vcs_regs_tb_top;
  logic clock, srst, hwrite, hsel, hreadyout, sawSync;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic masterMode, positionStrobePin, overlapInputPin, horizBlankingIn;
  logic vertBlankingIn, soundEmpty, majorLoadBusy, gridInterval;
  logic lumaGate, interruptReq, overlapOutPin;
  logic vertBlankingGen, hresp;
  logic [7:0] objectActive, beamLocationX, beamLocationY, rd;
  vcs_pkg::vcs_sync_s syncOut;
  vcs_pkg::vcs_video_s videoCtl;
  int nMismatch = 0;
  int testsRun = 0;
  int n;

  vcs_regs i_vcs_regs (.clock(clock), .srst(srst), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .masterMode(masterMode),
    .positionStrobePin(positionStrobePin),
    .overlapInputPin(overlapInputPin), .horizBlankingIn(horizBlankingIn),
    .vertBlankingIn(vertBlankingIn), .vertBlankingGen(vertBlankingGen),
    .objectActive(objectActive), .soundEmpty(soundEmpty),
    .majorLoadBusy(majorLoadBusy), .beamLocationX(beamLocationX),
    .beamLocationY(beamLocationY), .gridInterval(gridInterval),
    .syncOut(syncOut), .videoCtl(videoCtl), .overlapOutPin(overlapOutPin),
    .lumaGate(lumaGate), .interruptReq(interruptReq));

  vcs_host_model i_vcs_host_model (.clock(clock), .hready(hreadyout),
    .hrdata(hrdata), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hsel(hsel));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_vcs_host_model.xfer(1'b1, a, d, rd);
  endtask
  // masked read compare; volatile status bits are masked out
  task automatic rdc(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    i_vcs_host_model.xfer(1'b0, a, 8'h00, rd);
    chk(rd & m, e);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask
  task automatic waitRise(output int k);
    logic prev;
    prev = syncOut.horizBlanking;
    k = 0;
    do begin
      @(posedge clock);
      k++;
      if (syncOut.horizSync === 1'b1) sawSync = 1'b1;
      if (syncOut.horizBlanking === 1'b1 && prev === 1'b0) break;
      prev = syncOut.horizBlanking;
    end while (k < 2000);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // whole sequence needs well under 10000 cycles
  initial begin
    repeat (60000) @(posedge clock);
    nMismatch++;
    $display("ERROR t=%0t watchdog expired", $time);
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst = 1'b1; masterMode = 1'b0; positionStrobePin = 1'b0;
    overlapInputPin = 1'b0; horizBlankingIn = 1'b0; vertBlankingIn = 1'b0;
    soundEmpty = 1'b0; majorLoadBusy = 1'b0; gridInterval = 1'b1;
    objectActive = 8'h00; beamLocationX = 8'h00; beamLocationY = 8'h00;
    sawSync = 1'b0;
    vertBlankingGen = 1'b0;
    cyc(6);
    srst <= 1'b0;
    cyc(1);
    rdc(vcs_pkg::ADDR_CONTROL, 8'hFF, vcs_pkg::CONTROL_RST);
    chk({7'h00, interruptReq}, 8'h00);
    chk({7'h00, hresp}, 8'h00);
    for (int i = 3; i < 8; i++) begin
      if (i == 4) continue;
      wr(vcs_pkg::ADDR_CONTROL, 8'(1 << i));
      rdc(vcs_pkg::ADDR_CONTROL, 8'hFF, 8'(1 << i));
      chk({4'h0, videoCtl.gridEnable, videoCtl.displayEnable,
           videoCtl.dotEnable, videoCtl.wideGrid},
          {4'h0, i == 3, i == 5, i == 6, i == 7});
      chk({7'h00, lumaGate}, {7'h00, i == 3});
    end
    wr(vcs_pkg::ADDR_CONTROL, 8'h00);
    wr(vcs_pkg::ADDR_COLOUR, 8'h55);
    cyc(1);
    chk({videoCtl.gridBright, 1'b0, videoCtl.backRgb, videoCtl.gridRgb},
        8'h95);
    // overlaps: unmasked pairs, masking, clear on read, pin bit
    objectActive <= 8'h03; cyc(3);
    chk({7'h00, overlapOutPin}, 8'h01);
    objectActive <= 8'h00; cyc(2);
    rdc(vcs_pkg::ADDR_OVERLAP, 8'hFF, 8'h03);
    rdc(vcs_pkg::ADDR_OVERLAP, 8'hFF, 8'h00);
    wr(vcs_pkg::ADDR_OVERLAP, 8'hFE);
    objectActive <= 8'h03; cyc(3); objectActive <= 8'h00; cyc(2);
    rdc(vcs_pkg::ADDR_OVERLAP, 8'hFF, 8'h00);
    objectActive <= 8'h0E; cyc(3); objectActive <= 8'h00; cyc(2);
    rdc(vcs_pkg::ADDR_OVERLAP, 8'hFF, 8'h0E);
    wr(vcs_pkg::ADDR_OVERLAP, 8'hFF);
    objectActive <= 8'h01; overlapInputPin <= 1'b1; cyc(4);
    objectActive <= 8'h00; overlapInputPin <= 1'b0; cyc(4);
    rdc(vcs_pkg::ADDR_OVERLAP, 8'hFF, 8'h41);
    // status flags and the interrupt flip-flop
    wr(vcs_pkg::ADDR_CONTROL, 8'h14);
    rdc(vcs_pkg::ADDR_STATUS, 8'h00, 8'h00);
    soundEmpty <= 1'b1; cyc(1); soundEmpty <= 1'b0; cyc(3);
    chk({7'h00, interruptReq}, 8'h01);
    rdc(vcs_pkg::ADDR_STATUS, 8'hC4, 8'h04);
    cyc(2);
    chk({7'h00, interruptReq}, 8'h00);
    rdc(vcs_pkg::ADDR_STATUS, 8'hC4, 8'h00);
    // the pin only counts as an overlap while a local object is shown
    overlapInputPin <= 1'b1; majorLoadBusy <= 1'b1; objectActive <= 8'h01;
    cyc(1);
    majorLoadBusy <= 1'b0; cyc(2);
    overlapInputPin <= 1'b0; objectActive <= 8'h00; cyc(3);
    chk({7'h00, interruptReq}, 8'h01);
    rdc(vcs_pkg::ADDR_STATUS, 8'hC4, 8'hC0);
    rdc(vcs_pkg::ADDR_STATUS, 8'hC4, 8'h80);
    rdc(vcs_pkg::ADDR_OVERLAP, 8'h00, 8'h00);
    wr(vcs_pkg::ADDR_CONTROL, 8'h00);
    soundEmpty <= 1'b1; cyc(1); soundEmpty <= 1'b0; cyc(3);
    chk({7'h00, interruptReq}, 8'h00);
    rdc(vcs_pkg::ADDR_STATUS, 8'h04, 8'h04);
    // slave mode: horizontal and vertical status follow incoming blanking
    wr(vcs_pkg::ADDR_CONTROL, 8'h01);
    horizBlankingIn <= 1'b1; cyc(4);
    chk({7'h00, interruptReq}, 8'h01);
    rdc(vcs_pkg::ADDR_STATUS, 8'h01, 8'h01);
    wr(vcs_pkg::ADDR_CONTROL, 8'h00);
    horizBlankingIn <= 1'b0; cyc(4);
    rdc(vcs_pkg::ADDR_STATUS, 8'h01, 8'h00);
    cyc(2);
    chk({7'h00, interruptReq}, 8'h00);
    vertBlankingIn <= 1'b1; cyc(4);
    rdc(vcs_pkg::ADDR_STATUS, 8'h08, 8'h08);
    vertBlankingIn <= 1'b0;
    chk({4'h0, syncOut}, 8'h00);
    // beam position tracking, freezing and forced strobe
    beamLocationX <= 8'h3C; beamLocationY <= 8'h5A;
    positionStrobePin <= 1'b1; cyc(4);
    rdc(vcs_pkg::ADDR_STATUS, 8'h02, 8'h02);
    rdc(vcs_pkg::ADDR_XPOS, 8'hFF, 8'h3C);
    beamLocationX <= 8'h3D; cyc(4);
    rdc(vcs_pkg::ADDR_XPOS, 8'hFF, 8'h3D);
    positionStrobePin <= 1'b0; cyc(4);
    beamLocationX <= 8'h77; cyc(4);
    rdc(vcs_pkg::ADDR_STATUS, 8'h02, 8'h00);
    rdc(vcs_pkg::ADDR_YPOS, 8'hFF, 8'h5A);
    rdc(vcs_pkg::ADDR_XPOS, 8'hFF, 8'h3D);
    wr(vcs_pkg::ADDR_CONTROL, 8'h02); cyc(4);
    rdc(vcs_pkg::ADDR_XPOS, 8'hFF, 8'h77);
    wr(vcs_pkg::ADDR_CONTROL, 8'h00);
    rdc(8'h20, 8'hFF, 8'h00);
    // master mode: line period is 227 video ticks, about 1603 clocks
    masterMode <= 1'b1;
    vertBlankingGen <= 1'b1;
    waitRise(n);
    waitRise(n);
    chk({7'h00, n >= 1602 && n <= 1605}, 8'h01);
    chk({7'h00, sawSync}, 8'h01);
    chk({7'h00, syncOut.vertBlanking}, 8'h01);
    rdc(vcs_pkg::ADDR_STATUS, 8'h08, 8'h08);
    vertBlankingGen <= 1'b0;
    cyc(2);
    chk({7'h00, syncOut.vertBlanking}, 8'h00);
    final_report();
  end
endmodule
